// ===== gpb_pkg.sv
// constants and carrier types for the general purpose pin configuration bank
package gpb_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int          GPB_NUM_PINS   = 10;
  localparam int          GPB_ADDR_W     = 12;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [7:0]  GPB_IDX_PIN_2_5 = 8'h30;
  localparam logic [7:0]  GPB_IDX_PIN_2_6 = 8'h31;
  localparam logic [7:0]  GPB_IDX_PIN_2_7 = 8'h32;
  localparam logic [7:0]  GPB_IDX_PIN_3_0 = 8'h33;
  localparam logic [7:0]  GPB_IDX_PIN_3_1 = 8'h34;
  localparam logic [7:0]  GPB_IDX_PIN_3_2 = 8'h35;
  localparam logic [7:0]  GPB_IDX_PIN_3_3 = 8'h36;
  localparam logic [7:0]  GPB_IDX_PIN_3_4 = 8'h37;
  localparam logic [7:0]  GPB_IDX_PIN_3_5 = 8'h38;
  localparam logic [7:0]  GPB_IDX_PIN_3_6 = 8'h39;
  localparam logic [7:0]  GPB_IDX_DATA    = 8'h3E; // pin output values
  localparam logic [7:0]  GPB_IDX_LEVEL   = 8'h3F; // pin levels, read only

  // ****************************************************************
  // configuration field positions
  // ****************************************************************
  localparam int          GPB_BIT_DIR    = 0; // 1 input, 0 output
  localparam int          GPB_BIT_POL    = 1; // 1 invert
  localparam int          GPB_BIT_ALT    = 2; // 1 alternate function
  localparam int          GPB_BIT_ODRAIN = 7; // 1 open drain

  // ****************************************************************
  // reset values and writable masks
  // ****************************************************************
  localparam logic [7:0]  GPB_CFG_RESET      = 8'h01; // standby power-on
  localparam logic [7:0]  GPB_CFG_HOST_RESET = 8'h00; // main power / host reset
  localparam logic [7:0]  GPB_WMASK_ALT      = 8'h87;
  localparam logic [7:0]  GPB_WMASK_NOALT    = 8'h83;
  localparam logic [9:0]  GPB_DATA_RESET     = 10'h000;
  localparam logic [9:0]  GPB_HAS_ALT        = 10'h3FD; // pin 2.6 has none
  localparam int          GPB_FAN_PIN        = 6;       // pin 3.3 slot

  // ****************************************************************
  // bus answers
  // ****************************************************************
  localparam logic [1:0]  GPB_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  GPB_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // carrier types
  // ****************************************************************
  typedef struct packed {
    logic [GPB_NUM_PINS-1:0] value;
    logic [GPB_NUM_PINS-1:0] enable;
  } gpb_pad_drive_type;

endpackage : gpb_pkg

// ===== gpb_pin_bank.sv
// ten-pin configuration bank with AXI4-Lite register access and pad drive
//
// Behaviour
// - bit 0 sets direction, one input, zero output.
// - bit 1 inverts the pin value between register and pad.
// - bit 7 picks open-drain when one, push-pull when zero.
// - pin 2.5 bit 2 routes the keyboard controller port bit twelve.
// - pin 2.6 has no alternate function; bits 6 to 2 reserved.
// - pin 2.7 bit 2 carries the system management interrupt output.
// - pin 3.0 bit 2 drives expansion chip select two.
// - pin 3.1 bit 2 drives expansion chip select three.
// - pin 3.2 bit 2 connects the fan tachometer input.
// - pin 3.3 bit 2 carries fan output; resets 0x01, host reset 0x00.
// - pin 3.4 bit 2 makes it interrupt request input A.
// - pin 3.5 bit 2 makes it interrupt request input B.
// - pin 3.6 bit 2 carries the active-low keyboard reset output.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps

module gpb_pin_bank (
  input  wire logic                                  aclk,
  input  wire logic                                  aresetn,
  input  wire logic                                  host_reset_n,
  // write address channel
  input  wire logic                                  s_axi_awvalid,
  output      logic                                  s_axi_awready,
  input  wire logic [gpb_pkg::GPB_ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic [2:0]                            s_axi_awprot,
  // write data channel
  input  wire logic                                  s_axi_wvalid,
  output      logic                                  s_axi_wready,
  input  wire logic [31:0]                           s_axi_wdata,
  input  wire logic [3:0]                            s_axi_wstrb,
  // write response channel
  output      logic                                  s_axi_bvalid,
  input  wire logic                                  s_axi_bready,
  output      logic [1:0]                            s_axi_bresp,
  // read address channel
  input  wire logic                                  s_axi_arvalid,
  output      logic                                  s_axi_arready,
  input  wire logic [gpb_pkg::GPB_ADDR_W-1:0]        s_axi_araddr,
  input  wire logic [2:0]                            s_axi_arprot,
  // read data channel
  output      logic                                  s_axi_rvalid,
  input  wire logic                                  s_axi_rready,
  output      logic [31:0]                           s_axi_rdata,
  output      logic [1:0]                            s_axi_rresp,
  // pads, slot 0 is pin 2.5 through slot 9 is pin 3.6
  input  wire logic [gpb_pkg::GPB_NUM_PINS-1:0]      pad_in,
  output      gpb_pkg::gpb_pad_drive_type            pad_drive,
  // alternate function sources from the core
  input  wire logic                                  kbc_port_bit_twelve_drive,
  input  wire logic                                  system_mgmt_interrupt_out,
  input  wire logic                                  expansion_chip_select_two,
  input  wire logic                                  expansion_chip_select_three,
  input  wire logic                                  fan_speed_out,
  input  wire logic                                  keyboard_reset_out,
  // alternate function inputs to the core
  output      logic                                  kbc_port_bit_twelve_in,
  output      logic                                  fan_tachometer_input,
  output      logic                                  irq_request_input_a,
  output      logic                                  irq_request_input_b
);

  localparam int NP = gpb_pkg::GPB_NUM_PINS;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [7:0]      cfg [NP];
  logic [NP-1:0]   data_out;
  logic            aw_held;
  logic            w_held;
  logic [9:0]      aw_idx;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            host_rst_meta;
  logic            host_rst_sync;
  logic [NP-1:0]   pad_meta;
  logic [NP-1:0]   pad_sync;
  logic [NP-1:0]   alt_in_q;
  gpb_pkg::gpb_pad_drive_type pad_q;

  // ****************************************************************
  // combinational nets
  // ****************************************************************
  wire  [7:0]      idx_table [NP];
  wire  [NP-1:0]   alt_src;
  wire  [NP-1:0]   alt_sel;
  wire  [NP-1:0]   in_view;
  wire  [NP-1:0]   wr_cfg_hit;
  wire  [NP-1:0]   rd_cfg_hit;
  wire  [NP-1:0]   next_pad_value;
  wire  [NP-1:0]   next_pad_enable;
  wire  [NP-1:0]   next_alt_in;
  wire  [9:0]      ar_idx;
  wire             wr_fire;
  wire             ar_fire;
  wire             wr_data_hit;
  wire             wr_any_hit;
  wire             rd_data_hit;
  wire             rd_level_hit;
  wire             rd_any_hit;
  logic [31:0]     rd_value;

  // ****************************************************************
  // address table and alternate function wiring
  // ****************************************************************
  assign idx_table[0] = gpb_pkg::GPB_IDX_PIN_2_5;
  assign idx_table[1] = gpb_pkg::GPB_IDX_PIN_2_6;
  assign idx_table[2] = gpb_pkg::GPB_IDX_PIN_2_7;
  assign idx_table[3] = gpb_pkg::GPB_IDX_PIN_3_0;
  assign idx_table[4] = gpb_pkg::GPB_IDX_PIN_3_1;
  assign idx_table[5] = gpb_pkg::GPB_IDX_PIN_3_2;
  assign idx_table[6] = gpb_pkg::GPB_IDX_PIN_3_3;
  assign idx_table[7] = gpb_pkg::GPB_IDX_PIN_3_4;
  assign idx_table[8] = gpb_pkg::GPB_IDX_PIN_3_5;
  assign idx_table[9] = gpb_pkg::GPB_IDX_PIN_3_6;

  // sources driven onto pads when the alternate function is chosen
  assign alt_src[0] = kbc_port_bit_twelve_drive;
  assign alt_src[1] = 1'b0;
  assign alt_src[2] = system_mgmt_interrupt_out;
  assign alt_src[3] = expansion_chip_select_two;
  assign alt_src[4] = expansion_chip_select_three;
  assign alt_src[5] = 1'b0;                        // tach is input only
  assign alt_src[6] = fan_speed_out;
  assign alt_src[7] = 1'b0;                        // request is input only
  assign alt_src[8] = 1'b0;                        // request is input only
  assign alt_src[9] = keyboard_reset_out;

  // alternate inputs handed to the core, registered
  assign kbc_port_bit_twelve_in = alt_in_q[0];
  assign fan_tachometer_input   = alt_in_q[5];
  assign irq_request_input_a    = alt_in_q[7];
  assign irq_request_input_b    = alt_in_q[8];

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign wr_fire      = aw_held & w_held & ~s_axi_bvalid;
  assign ar_fire      = s_axi_arvalid & s_axi_arready;
  assign ar_idx       = s_axi_araddr[gpb_pkg::GPB_ADDR_W-1:2];
  assign wr_data_hit  = aw_idx == {2'h0, gpb_pkg::GPB_IDX_DATA};
  assign rd_data_hit  = ar_idx == {2'h0, gpb_pkg::GPB_IDX_DATA};
  assign rd_level_hit = ar_idx == {2'h0, gpb_pkg::GPB_IDX_LEVEL};
  assign wr_any_hit   = (|wr_cfg_hit) | wr_data_hit;
  assign rd_any_hit   = (|rd_cfg_hit) | rd_data_hit | rd_level_hit;

  // handshake readies, one write and one read in flight at a time
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  assign pad_drive = pad_q;

  // ****************************************************************
  // per pin logic
  // ****************************************************************
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi = gi + 1) begin : g_pin
      wire [7:0] wmask;
      wire       src;
      wire       lvl;
      wire       drive;
      wire       odrain;

      assign wr_cfg_hit[gi] = aw_idx == {2'h0, idx_table[gi]};
      assign rd_cfg_hit[gi] = ar_idx == {2'h0, idx_table[gi]};

      // reserved bits never store
      assign wmask = gpb_pkg::GPB_HAS_ALT[gi] ? gpb_pkg::GPB_WMASK_ALT
                                              : gpb_pkg::GPB_WMASK_NOALT;
      assign alt_sel[gi] = cfg[gi][gpb_pkg::GPB_BIT_ALT] &
                           gpb_pkg::GPB_HAS_ALT[gi];

      // value toward the pad, inverted when asked
      assign src    = alt_sel[gi] ? alt_src[gi] : data_out[gi];
      assign lvl    = src ^ cfg[gi][gpb_pkg::GPB_BIT_POL];
      assign drive  = ~cfg[gi][gpb_pkg::GPB_BIT_DIR];
      assign odrain = cfg[gi][gpb_pkg::GPB_BIT_ODRAIN];

      // open drain only pulls low; push-pull drives both levels
      assign next_pad_value[gi]  = ~odrain & lvl;
      assign next_pad_enable[gi] = drive & (~odrain | ~lvl);

      // pad level seen by software and the core, inverted when asked
      assign in_view[gi]     = pad_sync[gi] ^ cfg[gi][gpb_pkg::GPB_BIT_POL];
      assign next_alt_in[gi] = alt_sel[gi] & in_view[gi];

      // configuration store; host reset clears the fan pin only
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          cfg[gi] <= gpb_pkg::GPB_CFG_RESET;
        end else if (gi == gpb_pkg::GPB_FAN_PIN && !host_rst_sync) begin
          cfg[gi] <= gpb_pkg::GPB_CFG_HOST_RESET;
        end else if (wr_fire && wr_cfg_hit[gi] && w_strb[0]) begin
          cfg[gi] <= w_data[7:0] & wmask;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // synchronisers
  // ****************************************************************
  // pads and host reset arrive from outside the clock domain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_meta      <= '0;
      pad_sync      <= '0;
      host_rst_meta <= 1'b1;
      host_rst_sync <= 1'b1;
    end else begin
      pad_meta      <= pad_in;
      pad_sync      <= pad_meta;
      host_rst_meta <= host_reset_n;
      host_rst_sync <= host_rst_meta;
    end
  end

  // ****************************************************************
  // pad drive and alternate inputs
  // ****************************************************************
  // all pads float after reset since every pin starts as an input
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_q    <= '0;
      alt_in_q <= '0;
    end else begin
      pad_q.value  <= next_pad_value;
      pad_q.enable <= next_pad_enable;
      alt_in_q     <= next_alt_in;
    end
  end

  // ****************************************************************
  // output data register
  // ****************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      data_out <= gpb_pkg::GPB_DATA_RESET;
    end else if (wr_fire && wr_data_hit) begin
      if (w_strb[0]) begin
        data_out[7:0] <= w_data[7:0];
      end
      if (w_strb[1]) begin
        data_out[NP-1:8] <= w_data[NP-1:8];
      end
    end
  end

  // ****************************************************************
  // write channel
  // ****************************************************************
  // address and data are caught separately, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_idx  <= s_axi_awaddr[gpb_pkg::GPB_ADDR_W-1:2];
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  // response once both halves are in; unmapped gets an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gpb_pkg::GPB_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_any_hit ? gpb_pkg::GPB_RESP_OKAY
                                 : gpb_pkg::GPB_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  // read mux, reserved and unmapped bits read as zero
  always_comb begin
    rd_value = '0;
    for (int i = 0; i < NP; i++) begin
      if (rd_cfg_hit[i]) begin
        rd_value[7:0] = cfg[i];
      end
    end
    if (rd_data_hit) begin
      rd_value[NP-1:0] = data_out;
    end
    if (rd_level_hit) begin
      rd_value[NP-1:0] = in_view;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= gpb_pkg::GPB_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_value;
      s_axi_rresp  <= rd_any_hit ? gpb_pkg::GPB_RESP_OKAY
                                 : gpb_pkg::GPB_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : gpb_pin_bank

// ===== gpb_pin_bank_checker.sv
// port assertions for the pin configuration bank
`timescale 1ns/1ps
module gpb_pin_bank_checker (
  input wire logic                       aclk,
  input wire logic                       aresetn,
  input wire logic                       host_reset_n,
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 s_axi_bresp,
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  input wire gpb_pkg::gpb_pad_drive_type pad_drive,
  input wire logic                       kbc_port_bit_twelve_in,
  input wire logic                       fan_tachometer_input,
  input wire logic                       irq_request_input_a,
  input wire logic                       irq_request_input_b
);
  // ****************************************************************
  // properties
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_reset_idle;
    $rose(aresetn) |-> pad_drive.enable == 10'h000 && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("drive after reset");
  property p_alt_idle;
    $rose(aresetn) |-> {kbc_port_bit_twelve_in, fan_tachometer_input,
                        irq_request_input_a, irq_request_input_b} == 4'h0;
  endproperty
  a_alt_idle: assert property (p_alt_idle) else $error("alt input after reset");
  property p_host_fan;
    (!host_reset_n)[*5] |=> pad_drive.enable[gpb_pkg::GPB_FAN_PIN];
  endproperty
  a_host_fan: assert property (p_host_fan) else $error("fan pin not output");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_blat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_blat: assert property (p_blat) else $error("write answer late");
  property p_err_zero;
    s_axi_rvalid && s_axi_rresp == gpb_pkg::GPB_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_width;
    s_axi_rvalid && s_axi_arready == 1'b0 |-> s_axi_rdata[31:10] == 22'h0;
  endproperty
  a_width: assert property (p_width) else $error("read above field");
  c_reset: cover property ($rose(aresetn));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == gpb_pkg::GPB_RESP_SLVERR);
  c_host: cover property ((!host_reset_n)[*5]);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule : gpb_pin_bank_checker

// ===== gpb_board_model.sv
// board side of the ten pads: resolves each wire and feeds it back
`timescale 1ns/1ps
module gpb_board_model (
  input  wire gpb_pkg::gpb_pad_drive_type pad_drive,
  input  wire logic [9:0]                 board_en,
  input  wire logic [9:0]                 board_val,
  output      logic [9:0]                 pad_in
);
  // chip drive first, then the board, released wires float up
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      pad_in[i] = pad_drive.enable[i] ? pad_drive.value[i] :
                  (board_en[i] ? board_val[i] : 1'b1);
    end
  end
endmodule : gpb_board_model

// ===== gpb_pin_bank_bench.sv
// self-checking bench for the pin configuration bank
`timescale 1ns/1ps
module gpb_pin_bank_bench;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [7:0] P0 = gpb_pkg::GPB_IDX_PIN_2_5;
  localparam logic [1:0] OK = gpb_pkg::GPB_RESP_OKAY;
  localparam logic [1:0] ER = gpb_pkg::GPB_RESP_SLVERR;
  logic                       aclk, aresetn, host_reset_n;
  logic                       aw_v, aw_r, w_v, w_r, b_v, b_r, ar_v, ar_r, r_v, r_r;
  logic [11:0]                aw_a, ar_a;
  logic [31:0]                w_d, r_d, seed, s;
  logic [1:0]                 b_resp, r_resp;
  logic [9:0]                 pad_in, ben, bval, d, g, o, k, p, a;
  logic [5:0]                 src;
  logic                       kin, tin, ia, ib;
  gpb_pkg::gpb_pad_drive_type pd;
  logic [33:0]                bq[$], rq[$];
  logic [7:0]                 om[6] = '{8'h00, 8'h02, 8'h80, 8'h82, 8'h04, 8'h86};
  logic [7:0]                 im[4] = '{8'h01, 8'h03, 8'h05, 8'h07};
  int                         miscompares, compares;

  gpb_pin_bank dut_u (.aclk(aclk), .aresetn(aresetn), .host_reset_n(host_reset_n),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_awaddr(aw_a), .s_axi_awprot(3'h0),
    .s_axi_wvalid(w_v), .s_axi_wready(w_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(b_v), .s_axi_bready(b_r), .s_axi_bresp(b_resp),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
    .s_axi_rvalid(r_v), .s_axi_rready(r_r), .s_axi_rdata(r_d), .s_axi_rresp(r_resp),
    .pad_in(pad_in), .pad_drive(pd), .kbc_port_bit_twelve_drive(src[5]),
    .system_mgmt_interrupt_out(src[4]), .expansion_chip_select_two(src[3]),
    .expansion_chip_select_three(src[2]), .fan_speed_out(src[1]),
    .keyboard_reset_out(src[0]), .kbc_port_bit_twelve_in(kin),
    .fan_tachometer_input(tin), .irq_request_input_a(ia), .irq_request_input_b(ib));
  gpb_board_model board_u (.pad_drive(pd), .board_en(ben), .board_val(bval), .pad_in(pad_in));

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk_bus(input logic [33:0] e, input logic [33:0] r);
    compares++;
    if (r !== e) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, r);
    end
  endtask : chk_bus
  task automatic chk_pin(input logic [31:0] e, input logic [31:0] r);
    chk_bus({2'b00, e}, {2'b00, r});
  endtask : chk_pin
  task automatic tmo();
    miscompares++;
    $display("ERROR t=%0t wait exp=%h got=%h", $time, 1'b1, 1'b0);
    end_sim();
  endtask : tmo
  task automatic end_sim();
    $display("TB: compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  // write: address and data together, response taken a cycle after it shows
  task automatic bus_wr(input logic [7:0] idx, input logic [31:0] v, input logic [1:0] e);
    bit done;
    @(posedge aclk);
    bq.push_back({32'h0, e});
    aw_a <= {2'b00, idx, 2'b00};
    w_d <= v;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    done = 0;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (aw_v && aw_r) aw_v <= 1'b0;
      if (w_v && w_r) w_v <= 1'b0;
      if (b_v && b_r) done = 1;
      else if (b_v) b_r <= 1'b1;
    end
    b_r <= 1'b0;
    if (!done) tmo();
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] idx, input logic [33:0] e);
    bit done;
    @(posedge aclk);
    rq.push_back(e);
    ar_a <= {2'b00, idx, 2'b00};
    ar_v <= 1'b1;
    done = 0;
    for (int n = 0; n < 64 && !done; n++) begin
      @(posedge aclk);
      if (ar_v && ar_r) ar_v <= 1'b0;
      if (r_v && r_r) done = 1;
      else if (r_v) r_r <= 1'b1;
    end
    r_r <= 1'b0;
    if (!done) tmo();
  endtask : bus_rd
  task automatic setall(input logic [7:0] c);
    for (int i = 0; i < 10; i++) bus_wr(P0 + 8'(i), {24'h0, c}, OK);
  endtask : setall

  // ****************************************************************
  // clock, answer monitor, main sequence
  // ****************************************************************
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    if (b_v && b_r) chk_bus(bq.pop_front(), {32'h0, b_resp});
    if (r_v && r_r) chk_bus(rq.pop_front(), {r_resp, r_d});
  end
  initial begin
    {aresetn, aw_v, w_v, b_r, ar_v, r_r, src, ben, bval} = '0;
    {aw_a, ar_a, w_d} = '0;
    host_reset_n = 1'b1;
    seed = 32'h00000CDE;
    miscompares = 0;
    compares = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 10; i++) bus_rd(P0 + 8'(i), {OK, 32'h01});
    bus_rd(8'h00, {ER, 32'h0});
    bus_wr(8'h00, 32'hFF, ER);
    setall(8'hFF);
    for (int i = 0; i < 10; i++) bus_rd(P0 + 8'(i), {OK, 24'h0, i == 1 ? 8'h83 : 8'h87});
    $display("TB: reset and field test done");
    foreach (om[j]) begin
      s = xs();
      src <= s[5:0];
      d = s[25:16];
      bus_wr(gpb_pkg::GPB_IDX_DATA, {22'h0, d}, OK);
      setall(om[j]);
      repeat (2) @(posedge aclk);
      a = {src[0], 2'b00, src[1], 1'b0, src[2], src[3], src[4], 1'b0, src[5]};
      k = om[j][2] ? 10'h25F : 10'h3FF;
      g = om[j][2] ? (d & ~10'h25D) | (a & 10'h25D) : d;
      o = g ^ {10{om[j][1]}};
      chk_pin({12'h0, (om[j][7] ? 10'h0 : o) & k, (om[j][7] ? ~o : 10'h3FF) & k},
              {12'h0, pd.value & pd.enable & k, pd.enable & k});
    end
    $display("TB: output test done");
    foreach (im[j]) begin
      setall(im[j]);
      s = xs();
      ben <= 10'h3FF;
      bval <= s[9:0];
      repeat (4) @(posedge aclk);
      p = s[9:0] ^ {10{im[j][1]}};
      chk_pin({28'h0, im[j][2] ? {p[8], p[7], p[5], p[0]} : 4'h0},
              {28'h0, ib, ia, tin, kin});
      bus_rd(gpb_pkg::GPB_IDX_LEVEL, {OK, 22'h0, p});
    end
    ben <= 10'h000;
    $display("TB: input test done");
    host_reset_n <= 1'b0;
    repeat (6) @(posedge aclk);
    bus_rd(P0 + 8'd6, {OK, 32'h0});
    bus_wr(P0 + 8'd6, 32'h87, OK);
    bus_rd(P0 + 8'd6, {OK, 32'h0});
    host_reset_n <= 1'b1;
    repeat (3) @(posedge aclk);
    bus_wr(P0 + 8'd6, 32'h05, OK);
    bus_rd(P0 + 8'd6, {OK, 32'h05});
    $display("TB: host reset test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(P0 + 8'd6, {OK, 32'h01});
    $display("TB: second reset test done");
    end_sim();
  end
endmodule : gpb_pin_bank_bench

bind gpb_pin_bank gpb_pin_bank_checker chk_u (.aclk(aclk), .aresetn(aresetn),
  .host_reset_n(host_reset_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .pad_drive(pad_drive),
  .kbc_port_bit_twelve_in(kbc_port_bit_twelve_in), .fan_tachometer_input(fan_tachometer_input),
  .irq_request_input_a(irq_request_input_a), .irq_request_input_b(irq_request_input_b));
